/* rtl/power_stage_pwm_control.sv */
`timescale 1ns/10ps
`include "psg_regs.svh"

module power_stage_pwm_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic io_clk_tick,
    input wire logic [2:0] module_fault_pin,
    input wire logic [2:0] comparator_out,
    output logic [2:0] a_out,
    output logic [2:0] b_out,
    output logic irq
);

    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        logic [2:0] idx;
        unique case (addr)
            `OFS_POL: idx = `IDX_POL;
            `OFS_CTL: idx = `IDX_CTL;
            `OFS_MIC0: idx = `IDX_MIC0;
            `OFS_MIC1: idx = `IDX_MIC1;
            `OFS_MIC2: idx = `IDX_MIC2;
            `OFS_MSK: idx = `IDX_MSK;
            `OFS_FLG: idx = `IDX_FLG;
            default: idx = `IDX_NONE;
        endcase
        return idx;
    endfunction : reg_index

    logic awready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] pol_q;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] mic_q [3];
    logic [7:0] msk_q;
    logic [3:0] flg_q;
    logic [3:0] flg_d;
    logic irq_q;
    psg_pkg::gen_state_e state_q;
    psg_pkg::gen_state_e state_d;
    logic [7:0] pre_q;
    logic [7:0] pre_top;
    logic [7:0] cnt_q;
    logic [2:0] a_out_q;
    logic [2:0] b_out_q;

    wire [2:0] wr_idx = reg_index(s_axi_awaddr);
    wire [2:0] rd_idx = reg_index(s_axi_araddr);
    wire wr_fire = awready_q && s_axi_awvalid && s_axi_wvalid;
    wire wr_lane = wr_fire && s_axi_wstrb[0];
    wire [7:0] wbyte = s_axi_wdata[7:0];
    wire rd_fire = arready_q && s_axi_arvalid;

    // One write and one read in flight; address and data taken together
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end
        else
        begin
            awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q &&
                         !bvalid_q;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    logic [7:0] rd_val;
    always_comb
    begin
        unique case (rd_idx)
            `IDX_POL: rd_val = pol_q;
            `IDX_CTL: rd_val = ctl_q;
            `IDX_MIC0: rd_val = mic_q[0];
            `IDX_MIC1: rd_val = mic_q[1];
            `IDX_MIC2: rd_val = mic_q[2];
            `IDX_MSK: rd_val = msk_q;
            `IDX_FLG: rd_val = {4'h0, flg_q};
            default: rd_val = `REG_RESET;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_val};
                rresp_q <= (rd_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    // Fault path per module
    logic [2:0] fault_raw;
    logic [2:0] fault_in;
    logic [2:0] evt_now;
    logic [2:0] evt_q;
    logic [2:0] act_evt;
    logic [2:0] act_prev_q;
    logic [2:0] kill_a_own;
    logic [2:0] kill_b_own;
    logic [2:0] kill_all_src;
    logic [2:0] halt_src;
    logic [2:0] filt_q;
    logic [2:0] a_act;
    logic [2:0] b_act;

    wire kill_all = |kill_all_src;
    wire halt_evt = |halt_src;
    wire gen_on = state_q != psg_pkg::GEN_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_mod
            wire psg_pkg::action_mode_t mode =
                mic_q[gi][`MIC_MODE_HI:`MIC_MODE_LO];
            assign fault_raw[gi] = mic_q[gi][`MIC_SEL] ? comparator_out[gi]
                                                      : module_fault_pin[gi];
            assign fault_in[gi] = mic_q[gi][`MIC_FLT] ? filt_q[gi]
                                                     : fault_raw[gi];
            assign evt_now[gi] = fault_in[gi] == mic_q[gi][`MIC_LEV];
            // direct path unless async control set
            assign act_evt[gi] = (mode != 3'h0) &&
                (mic_q[gi][`MIC_AOC] ? evt_q[gi] : evt_now[gi]);
            assign kill_a_own[gi] = act_evt[gi] &&
                (mode == 3'h1 || mode == 3'h3);
            assign kill_b_own[gi] = act_evt[gi] &&
                (mode == 3'h2 || mode == 3'h3);
            assign kill_all_src[gi] = act_evt[gi] && mode[2:1] == 2'h2;
            assign halt_src[gi] = act_evt[gi] && mode[2:1] == 2'h3;
            assign a_act[gi] = gen_on && cnt_q < `A_END &&
                !kill_a_own[gi] && !kill_all &&
                !(!mic_q[gi][`MIC_OVP] && cnt_q >= `B_START);
            assign b_act[gi] = gen_on && cnt_q >= `B_START &&
                !kill_b_own[gi] && !kill_all &&
                !(!mic_q[gi][`MIC_OVP] && cnt_q < `A_END);

            // Filter keeps its last value until all samples agree
            logic [`FILT_LEN-1:0] smp_q;
            logic filt_bit_q;
            assign filt_q[gi] = filt_bit_q;
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    smp_q <= {`FILT_LEN{1'b0}};
                    filt_bit_q <= 1'b0;
                end
                else
                begin
                    smp_q <= {smp_q[`FILT_LEN-2:0], fault_raw[gi]};
                    if (&smp_q || ~|smp_q)
                        filt_bit_q <= smp_q[`FILT_LEN-1];
                end
            end
        end
    endgenerate

    always_comb
    begin
        unique case (ctl_q[`CTL_PRE_HI:`CTL_PRE_LO])
            2'h0: pre_top = `PRE_TOP_1;
            2'h1: pre_top = `PRE_TOP_4;
            2'h2: pre_top = `PRE_TOP_32;
            2'h3: pre_top = `PRE_TOP_256;
        endcase
    end

    // fast clock counts every edge, slow one on its tick
    wire src_tick = ctl_q[`CTL_CLKSEL] || io_clk_tick;
    wire tick = gen_on && src_tick && pre_q == pre_top;
    wire eoc = tick && cnt_q == `CYC_TOP;
    wire run_bit = ctl_q[`CTL_RUN];

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            psg_pkg::GEN_IDLE:
                if (run_bit && !halt_evt)
                    state_d = psg_pkg::GEN_RUN;
            psg_pkg::GEN_RUN:
                if (halt_evt)
                    state_d = psg_pkg::GEN_IDLE;
                else if (!run_bit)
                    state_d = ctl_q[`CTL_CCYC] ? psg_pkg::GEN_DRAIN
                                               : psg_pkg::GEN_IDLE;
            psg_pkg::GEN_DRAIN:
                if (halt_evt || eoc)
                    state_d = psg_pkg::GEN_IDLE;
                else if (run_bit)
                    state_d = psg_pkg::GEN_RUN;
        endcase
    end

    // hardware halt clears run so software must restart
    wire ctl_wr = wr_lane && wr_idx == `IDX_CTL;
    assign ctl_d = (ctl_wr ? (wbyte & `CTL_MASK) : ctl_q) &
                   ~(halt_evt ? 8'h01 : 8'h00);

    // event flags on event onset; cycle end flag
    wire [3:0] flg_set = {act_evt[2] && !act_prev_q[2],
                          act_evt[1] && !act_prev_q[1],
                          act_evt[0] && !act_prev_q[0], eoc};
    wire [7:0] flg_wbits = wbyte & `FLG_MASK;
    wire [3:0] flg_clr = (wr_lane && wr_idx == `IDX_FLG) ?
                         flg_wbits[3:0] : 4'h0;
    // write one clears; set ignores enables
    assign flg_d = (flg_q & ~flg_clr) | flg_set;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pol_q <= `REG_RESET;
            ctl_q <= `REG_RESET;
            msk_q <= `REG_RESET;
            flg_q <= 4'h0;
            for (int i = 0; i < 3; i++)
                mic_q[i] <= `REG_RESET;
        end
        else
        begin
            ctl_q <= ctl_d;
            flg_q <= flg_d;
            // masked writes keep unused bits zero
            if (wr_lane && wr_idx == `IDX_POL)
                pol_q <= wbyte & `POL_MASK;
            if (wr_lane && wr_idx == `IDX_MSK)
                msk_q <= wbyte & `MSK_MASK;
            for (int i = 0; i < 3; i++)
                if (wr_lane && wr_idx == `IDX_MIC0 + 3'(i))
                    mic_q[i] <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= psg_pkg::GEN_IDLE;
            pre_q <= 8'h00;
            cnt_q <= 8'h00;
            evt_q <= 3'h0;
            act_prev_q <= 3'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            evt_q <= evt_now;
            act_prev_q <= act_evt;
            if (!gen_on || (src_tick && pre_q == pre_top))
                pre_q <= 8'h00;
            else if (src_tick)
                pre_q <= pre_q + 8'h01;
            if (state_d == psg_pkg::GEN_IDLE)
                cnt_q <= 8'h00;
            else if (tick)
                cnt_q <= cnt_q + 8'h01;
            irq_q <= |(flg_q & msk_q[3:0]);
        end
    end

    // Outputs idle at their inactive level, so reset follows polarity zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            a_out_q <= 3'h7;
            b_out_q <= 3'h7;
        end
        else
        begin
            a_out_q <= pol_q[`POL_A] ? a_act : ~a_act;
            b_out_q <= pol_q[`POL_B] ? b_act : ~b_act;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = awready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign a_out = a_out_q;
    assign b_out = b_out_q;
    assign irq = irq_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_stop_req;
        state_q == psg_pkg::GEN_RUN && !run_bit && !halt_evt;
    endsequence

    property p_ccyc_drain;
        s_stop_req and ctl_q[`CTL_CCYC] |=> state_q == psg_pkg::GEN_DRAIN;
    endproperty
    a_ccyc_drain: assert property (p_ccyc_drain)
        else $error("complete cycle stop did not drain");

    property p_stop_now;
        s_stop_req and !ctl_q[`CTL_CCYC] |=> !gen_on ##1 cnt_q == 8'h00;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("generator did not stop at once");

    property p_halt;
        halt_evt |=> state_q == psg_pkg::GEN_IDLE && !run_bit;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt mode did not stop generator");

    property p_flag_set;
        act_evt[0] && !act_prev_q[0] |=> flg_q[1];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event flag not set");

    property p_w1c;
        wr_lane && wr_idx == `IDX_FLG && wbyte[0] && !eoc |=> !flg_q[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear flag");

    property p_eoc;
        eoc |=> flg_q[`FLG_EOC];
    endproperty
    a_eoc: assert property (p_eoc)
        else $error("cycle end flag not set");

    property p_irq;
        (flg_q[0] && msk_q[0]) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_irq_low;
        !(|(flg_q & msk_q[3:0])) |=> !irq_q;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt raised with nothing pending");

    property p_overlap;
        !mic_q[0][`MIC_OVP] |-> !(a_act[0] && b_act[0]);
    endproperty
    a_overlap: assert property (p_overlap)
        else $error("A and B active together");

    property p_pol_a;
        a_act[1] ##0 pol_q[`POL_A] |=> a_out_q[1];
    endproperty
    a_pol_a: assert property (p_pol_a)
        else $error("A output polarity wrong");

    property p_div4;
        gen_on && ctl_q[7:6] == 2'h1 && ctl_q[`CTL_CLKSEL] &&
            pre_q == 8'h00 && state_d != psg_pkg::GEN_IDLE |=>
            !tick [*2] ##1 (tick || !gen_on || ctl_q[7:5] != 3'h3);
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by four ticked early");

endmodule : power_stage_pwm_control

/* rtl/psg_pkg.sv */
package psg_pkg;

    typedef enum logic [1:0] {GEN_IDLE, GEN_RUN, GEN_DRAIN} gen_state_e;

    typedef logic [2:0] action_mode_t;

endpackage : psg_pkg

/* rtl/psg_regs.svh */
`ifndef PSG_REGS_SVH
`define PSG_REGS_SVH

// Register byte offsets
`define OFS_POL 8'h00
`define OFS_CTL 8'h04
`define OFS_MIC0 8'h08
`define OFS_MIC1 8'h0C
`define OFS_MIC2 8'h10
`define OFS_MSK 8'h14
`define OFS_FLG 8'h18

// Register indexes
`define IDX_POL 3'h0
`define IDX_CTL 3'h1
`define IDX_MIC0 3'h2
`define IDX_MIC1 3'h3
`define IDX_MIC2 3'h4
`define IDX_MSK 3'h5
`define IDX_FLG 3'h6
`define IDX_NONE 3'h7

// Writable bit masks, all reset values zero
`define POL_MASK 8'h0C
`define CTL_MASK 8'hE3
`define MSK_MASK 8'h0F
`define FLG_MASK 8'h0F
`define REG_RESET 8'h00

// Field positions
`define POL_B 3
`define POL_A 2
`define CTL_PRE_HI 7
`define CTL_PRE_LO 6
`define CTL_CLKSEL 5
`define CTL_CCYC 1
`define CTL_RUN 0
`define MIC_OVP 7
`define MIC_SEL 6
`define MIC_LEV 5
`define MIC_FLT 4
`define MIC_AOC 3
`define MIC_MODE_HI 2
`define MIC_MODE_LO 0
`define FLG_EOC 0

// Prescaler terminal counts for 1, 4, 32 and 256
`define PRE_TOP_1 8'h00
`define PRE_TOP_4 8'h03
`define PRE_TOP_32 8'h1F
`define PRE_TOP_256 8'hFF

// Waveform cycle shape
`define CYC_TOP 8'hFF
`define A_END 8'hA0
`define B_START 8'h60

// Noise filter sample count
`define FILT_LEN 4

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* tb/fault_source_model.sv */
`timescale 1ns/10ps

module fault_source_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] pin_level,
    input wire logic [2:0] cmp_level,
    input wire logic [1:0] tick_div,
    output logic io_clk_tick,
    output logic [2:0] module_fault_pin,
    output logic [2:0] comparator_out
);
    logic [1:0] tick_cnt_q;

    // Slow source strobes once every tick_div+1 edges
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_q <= 2'h0;
            io_clk_tick <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= (tick_cnt_q == tick_div) ? 2'h0 : tick_cnt_q + 2'h1;
            io_clk_tick <= (tick_cnt_q == tick_div);
        end
    end

    // pin and comparator levels
    // Registered so a level changes only at the device's sampling edge
    always_ff @(posedge sys_clk)
    begin
        module_fault_pin <= pin_level;
        comparator_out <= cmp_level;
    end
endmodule : fault_source_model

/* tb/power_stage_pwm_control_tb_top.sv */
`timescale 1ns/10ps
`include "psg_regs.svh"

module power_stage_pwm_control_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [2:0] pin_level = 3'h0;
    logic [2:0] cmp_level = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, io_clk_tick;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] module_fault_pin, comparator_out, a_out, b_out;
    logic [31:0] lfsr_q;
    int n_errors = 0;
    int samples_checked = 0;

    always #20 sys_clk = ~sys_clk;

    power_stage_pwm_control i_power_stage_pwm_control (
        .sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .io_clk_tick(io_clk_tick), .module_fault_pin(module_fault_pin),
        .comparator_out(comparator_out), .a_out(a_out), .b_out(b_out),
        .irq(irq)
    );

    fault_source_model i_fault_source_model (
        .sys_clk(sys_clk), .rst(rst), .pin_level(pin_level),
        .cmp_level(cmp_level), .tick_div(2'h2), .io_clk_tick(io_clk_tick),
        .module_fault_pin(module_fault_pin), .comparator_out(comparator_out)
    );

    task automatic print_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                n_errors++;
                $display("unexpected %s: expected %h seen %h", name, exp, seen);
            end
        end
    endtask : check

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Outputs as {b_out, a_out} that may ever be active under a fault
    function automatic logic [5:0] kill_exp(input int m);
        case (m)
            0: return 6'h3F;
            1: return 6'h3E;
            2: return 6'h37;
            3: return 6'h36;
            default: return 6'h00;
        endcase
    endfunction : kill_exp

    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [7:0] d, output logic [31:0] q, output logic [1:0] r);
        int n;
        logic got;
        begin
            got = 1'b0;
            q = 32'h0;
            r = 2'h0;
            @(posedge sys_clk);
            if (wr)
            begin
                awaddr <= a;
                wdata <= {24'h00_0000, d};
                awvalid <= 1'b1;
                wvalid <= 1'b1;
                bready <= 1'b1;
            end
            else
            begin
                araddr <= a;
                arvalid <= 1'b1;
                rready <= 1'b1;
            end
            for (n = 0; n < 50 && !got; n++)
            begin
                @(posedge sys_clk);
                if (awready === 1'b1)
                    awvalid <= 1'b0;
                if (wready === 1'b1)
                    wvalid <= 1'b0;
                if (arready === 1'b1)
                    arvalid <= 1'b0;
                if (wr ? bvalid === 1'b1 : rvalid === 1'b1)
                begin
                    got = 1'b1;
                    q = rdata;
                    r = wr ? bresp : rresp;
                    bready <= 1'b0;
                    rready <= 1'b0;
                end
            end
            if (!got)
            begin
                n_errors++;
                print_verdict();
            end
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic [1:0] r;
        begin
            xfer(1'b1, a, d, q, r);
            check("bresp", 32'(r), 32'(`RESP_OKAY));
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic [1:0] r;
        begin
            xfer(1'b0, a, 8'h00, q, r);
            check("rresp", 32'(r), 32'(`RESP_OKAY));
        end
    endtask : rd

    // Period of a_out[0] rising edges, and which modules showed A and B on
    task automatic measure(output int p, output logic [2:0] ov);
        int n;
        int t0;
        logic pa;
        begin
            ov = 3'h0;
            p = 0;
            t0 = -1;
            pa = 1'b1;
            for (n = 0; n < 20000 && p == 0; n++)
            begin
                @(negedge sys_clk);
                ov |= a_out & b_out;
                if (a_out[0] === 1'b1 && pa === 1'b0)
                begin
                    if (t0 < 0)
                        t0 = n;
                    else
                        p = n - t0;
                end
                pa = a_out[0];
            end
        end
    endtask : measure

    logic [7:0] ra [6] = '{`OFS_POL, `OFS_CTL, `OFS_MIC0, `OFS_MIC1,
        `OFS_MIC2, `OFS_MSK};
    logic [7:0] rm [6] = '{`POL_MASK, `CTL_MASK, 8'hFF, 8'hFF, 8'hFF,
        `MSK_MASK};
    // Run and action mode stay clear so random writes start nothing
    logic [7:0] rf [6] = '{8'h00, 8'h01, 8'h07, 8'h07, 8'h07, 8'h00};
    logic [7:0] sw [4] = '{8'h21, 8'h61, 8'hA1, 8'h01};
    int pe [4] = '{256, 1024, 8192, 768};
    // Input control, idle pin/cmp, active pin/cmp, pulse length, flag
    logic [15:0] ev [6] = '{16'h2129, 16'h01D9, 16'h6128, 16'h6119,
        16'h3126, 16'h312F};

    initial
    begin
        #4000000;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        int i;
        int p;
        logic [2:0] ov;
        logic [31:0] q;
        logic [1:0] r;
        logic [5:0] acc;
        logic [15:0] c;
        lfsr_q = 32'he9e2_edfe;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            rd(ra[i], q);
            check("reset value", q, 32'h0);
            lfsr_q = lfsr(lfsr_q);
            wr(ra[i], lfsr_q[7:0] & ~rf[i]);
            rd(ra[i], q);
            check("readback", q,
                32'(lfsr_q[7:0] & ~rf[i] & rm[i]));
            wr(ra[i], 8'h00);
        end
        xfer(1'b1, 8'h1C, 8'hFF, q, r);
        check("unmapped bresp", 32'(r), 32'(`RESP_SLVERR));
        xfer(1'b0, 8'h1C, 8'h00, q, r);
        check("unmapped rresp", 32'(r), 32'(`RESP_SLVERR));
        repeat (3) @(negedge sys_clk);
        check("idle a low", 32'(a_out), 32'h7);
        check("idle b low", 32'(b_out), 32'h7);
        wr(`OFS_POL, 8'h0C);
        repeat (3) @(negedge sys_clk);
        check("idle a high", 32'(a_out), 32'h0);
        check("idle b high", 32'(b_out), 32'h0);
        wr(`OFS_MIC0, 8'h80);
        for (i = 0; i < 4; i++)
        begin
            wr(`OFS_CTL, sw[i]);
            measure(p, ov);
            check("period", p, pe[i]);
            check("overlap", 32'(ov), 32'h1);
            wr(`OFS_CTL, 8'h00);
        end
        // Fast source so one full cycle ends inside the wait
        wr(`OFS_FLG, 8'h0F);
        wr(`OFS_CTL, 8'h21);
        repeat (300) @(negedge sys_clk);
        rd(`OFS_FLG, q);
        check("end flag", q, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        wr(`OFS_MSK, 8'h01);
        repeat (3) @(negedge sys_clk);
        check("irq end", 32'(irq), 32'h1);
        wr(`OFS_CTL, 8'h00);
        wr(`OFS_FLG, 8'h00);
        rd(`OFS_FLG, q);
        check("flag kept", q, 32'h1);
        wr(`OFS_FLG, 8'h01);
        repeat (3) @(negedge sys_clk);
        check("irq cleared", 32'(irq), 32'h0);
        for (i = 0; i < 2; i++)
        begin
            wr(`OFS_FLG, 8'h0F);
            wr(`OFS_CTL, {6'h08, i[0], 1'b1});
            repeat (100) @(posedge sys_clk);
            wr(`OFS_CTL, {6'h08, i[0], 1'b0});
            repeat (300) @(negedge sys_clk);
            rd(`OFS_FLG, q);
            check("halt end flag", q, 32'(i));
            check("halted a", 32'(a_out), 32'h0);
        end
        wr(`OFS_MSK, 8'h02);
        for (i = 0; i < 8; i++)
        begin
            // Fast source so both A and B phases pass in the window
            wr(`OFS_CTL, 8'h21);
            wr(`OFS_MIC0, 8'h20 | 8'(i));
            wr(`OFS_FLG, 8'h0F);
            pin_level <= 3'h1;
            acc = 6'h00;
            repeat (8) @(negedge sys_clk);
            repeat (300)
            begin
                @(negedge sys_clk);
                acc |= {b_out, a_out};
            end
            check("kill", 32'(acc),
                32'(kill_exp(i)));
            check("event irq", 32'(irq), 32'(i != 0));
            rd(`OFS_CTL, q);
            check("run bit", q, (i > 5) ? 32'h20 : 32'h21);
            pin_level <= 3'h0;
        end
        for (i = 0; i < 6; i++)
        begin
            c = ev[i];
            pin_level <= {2'h0, c[7]};
            cmp_level <= {2'h0, c[6]};
            wr(`OFS_MIC0, c[15:8]);
            repeat (10) @(posedge sys_clk);
            wr(`OFS_FLG, 8'h0F);
            pin_level <= {2'h0, c[5]};
            cmp_level <= {2'h0, c[4]};
            repeat (c[3:1]) @(posedge sys_clk);
            pin_level <= {2'h0, c[7]};
            cmp_level <= {2'h0, c[6]};
            repeat (10) @(posedge sys_clk);
            rd(`OFS_FLG, q);
            check("event flag", q & 32'h2,
                {30'h0, c[0], 1'b0});
        end
        print_verdict();
    end
endmodule : power_stage_pwm_control_tb_top
